// *** rtl/bdm_pkg.sv ***
/*
  Constants, register map and carrier types for the step-up and supply
  monitor event mask block.
  Assumes a single 200 MHz APB clock and an asynchronous active-low reset.
*/
`default_nettype none
package bdm_pkg;
  // Bus widths
  localparam int BDM_AW = 12;
  localparam int BDM_DW = 32;
  localparam int BDM_RW = 8;
  localparam int BDM_IW = 10;
  localparam logic [1:0] BDM_ALIGN_OK = 2'h0;
  // Register indices, byte address is four times the index
  localparam logic [BDM_IW-1:0] BDM_IDX_STEP_UP_MASK = 10'h02C;
  localparam logic [BDM_IW-1:0] BDM_IDX_SUPPLY_MASK = 10'h02D;
  localparam logic [BDM_IW-1:0] BDM_IDX_STEP_UP_EVT = 10'h040;
  localparam logic [BDM_IW-1:0] BDM_IDX_SUPPLY_EVT = 10'h041;
  localparam logic [BDM_IW-1:0] BDM_IDX_STATE = 10'h042;
  localparam logic [BDM_IW-1:0] BDM_IDX_STEP_UP_IRQ_MASK = 10'h043;
  localparam logic [BDM_IW-1:0] BDM_IDX_SUPPLY_IRQ_MASK = 10'h044;
  // Reset values
  localparam logic [BDM_RW-1:0] BDM_STEP_UP_MASK_RST = 8'h00;
  localparam logic [BDM_RW-1:0] BDM_SUPPLY_MASK_RST = 8'h00;
  // Mask fields of the step-up register
  localparam int BDM_SU_LOSS_BIT = 3;
  localparam int BDM_SU_GAIN_BIT = 2;
  localparam int BDM_SU_OC_BIT = 0;
  localparam logic [BDM_RW-1:0] BDM_SU_DEFINED = 8'h0D;
  // Mask fields of the supply monitor register
  localparam int BDM_M2_LOSS_BIT = 5;
  localparam int BDM_M2_GAIN_BIT = 4;
  localparam int BDM_M1_LOSS_BIT = 3;
  localparam int BDM_M1_GAIN_BIT = 2;
  localparam int BDM_AN_LOSS_BIT = 1;
  localparam int BDM_AN_GAIN_BIT = 0;
  localparam logic [BDM_RW-1:0] BDM_SM_DEFINED = 8'h3F;
  // Event flag layouts
  localparam int BDM_SU_EVT_W = 2;
  localparam int BDM_SU_EVT_OC = 0;
  localparam int BDM_SU_EVT_GOOD = 1;
  localparam int BDM_SM_EVT_W = 3;
  localparam int BDM_SM_EVT_AN = 0;
  localparam int BDM_SM_EVT_M1 = 1;
  localparam int BDM_SM_EVT_M2 = 2;
  // Live condition layout, also the state register layout
  localparam int BDM_LIVE_W = 5;
  localparam int BDM_LV_OC = 0;
  localparam int BDM_LV_SU = 1;
  localparam int BDM_LV_AN = 2;
  localparam int BDM_LV_M1 = 3;
  localparam int BDM_LV_M2 = 4;

  typedef struct packed {
    logic monitor_two_good_state;
    logic monitor_one_good_state;
    logic analog_supply_good_state;
    logic step_up_good_state;
    logic step_up_overcurrent_state;
  } bdm_live_type;

  typedef struct packed {
    logic load;
    logic [BDM_RW-1:0] step_up_mask;
    logic [BDM_RW-1:0] supply_mask;
  } bdm_otp_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [BDM_AW-1:0] paddr;
    logic [BDM_DW-1:0] pwdata;
    logic [3:0] pstrb;
  } bdm_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [BDM_DW-1:0] prdata;
  } bdm_apb_rsp_type;
endpackage
`default_nettype wire

// *** rtl/bdm_mask_ctrl.sv ***
/*
  Step-up converter and supply monitor event masks with APB register access,
  edge detection of live conditions, sticky event flags and one interrupt.
  Assumes live conditions and OTP load are synchronous to pclk, and that the
  APB master keeps to the APB protocol.
*/
// Local design decision: register access over APB.
// Operation
// - Step-up bit 3 masks good-loss event
// - Step-up bit 2 masks good-gain event
// - Step-up bit 0 masks overcurrent event
// - Step-up state bits ignore masks
// - Supply bit 5 masks monitor two loss
// - Supply bit 4 masks monitor two gain
// - Supply bit 3 masks monitor one loss
// - Supply bit 2 masks monitor one gain
// - Supply bit 1 masks analog supply loss
// - Supply bit 0 masks analog supply gain
// - Monitor state bits ignore masks
// - Defined mask bits load from OTP
// - Step-up mask at 2Ch, resets zero
// - Supply mask at 2Dh, resets zero
`default_nettype none
module bdm_mask_ctrl
  import bdm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire bdm_apb_req_type apb_req,
  output var bdm_apb_rsp_type apb_rsp,
  // Live conditions and OTP defaults
  input wire bdm_live_type live,
  input wire bdm_otp_type otp,
  // Interrupt
  output logic irq
);

  logic [BDM_RW-1:0] su_mask_r;
  logic [BDM_RW-1:0] sm_mask_r;
  logic [BDM_RW-1:0] su_mask_nxt;
  logic [BDM_RW-1:0] sm_mask_nxt;
  logic [BDM_SU_EVT_W-1:0] su_evt_r;
  logic [BDM_SU_EVT_W-1:0] su_evt_nxt;
  logic [BDM_SM_EVT_W-1:0] sm_evt_r;
  logic [BDM_SM_EVT_W-1:0] sm_evt_nxt;
  logic [BDM_SU_EVT_W-1:0] su_irqm_r;
  logic [BDM_SU_EVT_W-1:0] su_irqm_nxt;
  logic [BDM_SM_EVT_W-1:0] sm_irqm_r;
  logic [BDM_SM_EVT_W-1:0] sm_irqm_nxt;
  logic [BDM_LIVE_W-1:0] state_r;
  logic [BDM_LIVE_W-1:0] prev_r;
  logic armed_r;
  logic irq_r;
  logic irq_nxt;
  bdm_apb_rsp_type rsp_r;
  bdm_apb_rsp_type rsp_nxt;

  // Bus decode
  wire logic [BDM_LIVE_W-1:0] live_v = live;
  wire logic [BDM_IW-1:0] idx = apb_req.paddr[BDM_AW-1:2];
  wire logic aligned = (apb_req.paddr[1:0] == BDM_ALIGN_OK);
  wire logic access = apb_req.psel & apb_req.penable;
  wire logic commit = access & rsp_r.pready;
  wire logic hit_su_mask = aligned & (idx == BDM_IDX_STEP_UP_MASK);
  wire logic hit_sm_mask = aligned & (idx == BDM_IDX_SUPPLY_MASK);
  wire logic hit_su_evt = aligned & (idx == BDM_IDX_STEP_UP_EVT);
  wire logic hit_sm_evt = aligned & (idx == BDM_IDX_SUPPLY_EVT);
  wire logic hit_state = aligned & (idx == BDM_IDX_STATE);
  wire logic hit_su_irqm = aligned & (idx == BDM_IDX_STEP_UP_IRQ_MASK);
  wire logic hit_sm_irqm = aligned & (idx == BDM_IDX_SUPPLY_IRQ_MASK);
  wire logic hit_any = hit_su_mask | hit_sm_mask | hit_su_evt | hit_sm_evt | hit_state | hit_su_irqm | hit_sm_irqm;
  wire logic wr = commit & apb_req.pwrite & apb_req.pstrb[0];
  wire logic [BDM_RW-1:0] wbyte = apb_req.pwdata[BDM_RW-1:0];

  // Read selection
  wire logic [BDM_DW-1:0] rd_data =
    hit_su_mask ? {{(BDM_DW-BDM_RW){1'b0}}, su_mask_r} :
    hit_sm_mask ? {{(BDM_DW-BDM_RW){1'b0}}, sm_mask_r} :
    hit_su_evt ? {{(BDM_DW-BDM_SU_EVT_W){1'b0}}, su_evt_r} :
    hit_sm_evt ? {{(BDM_DW-BDM_SM_EVT_W){1'b0}}, sm_evt_r} :
    hit_state ? {{(BDM_DW-BDM_LIVE_W){1'b0}}, state_r} :
    hit_su_irqm ? {{(BDM_DW-BDM_SU_EVT_W){1'b0}}, su_irqm_r} :
    hit_sm_irqm ? {{(BDM_DW-BDM_SM_EVT_W){1'b0}}, sm_irqm_r} : {BDM_DW{1'b0}};

  // Edge detection, held off until the first sample after reset
  wire logic [BDM_LIVE_W-1:0] gain = live_v & ~prev_r & {BDM_LIVE_W{armed_r}};
  wire logic [BDM_LIVE_W-1:0] loss = ~live_v & prev_r & {BDM_LIVE_W{armed_r}};

  // Masked detections
  wire logic su_good_hit = (loss[BDM_LV_SU] & ~su_mask_r[BDM_SU_LOSS_BIT])
                         | (gain[BDM_LV_SU] & ~su_mask_r[BDM_SU_GAIN_BIT]);
  wire logic su_oc_hit = gain[BDM_LV_OC] & ~su_mask_r[BDM_SU_OC_BIT];
  wire logic m2_hit = (loss[BDM_LV_M2] & ~sm_mask_r[BDM_M2_LOSS_BIT])
                    | (gain[BDM_LV_M2] & ~sm_mask_r[BDM_M2_GAIN_BIT]);
  wire logic m1_hit = (loss[BDM_LV_M1] & ~sm_mask_r[BDM_M1_LOSS_BIT])
                    | (gain[BDM_LV_M1] & ~sm_mask_r[BDM_M1_GAIN_BIT]);
  wire logic an_hit = (loss[BDM_LV_AN] & ~sm_mask_r[BDM_AN_LOSS_BIT])
                    | (gain[BDM_LV_AN] & ~sm_mask_r[BDM_AN_GAIN_BIT]);

  wire logic [BDM_SU_EVT_W-1:0] su_set = {su_good_hit, su_oc_hit};
  wire logic [BDM_SM_EVT_W-1:0] sm_set = {m2_hit, m1_hit, an_hit};
  wire logic [BDM_SU_EVT_W-1:0] su_clr = (wr & hit_su_evt) ? wbyte[BDM_SU_EVT_W-1:0] : {BDM_SU_EVT_W{1'b0}};
  wire logic [BDM_SM_EVT_W-1:0] sm_clr = (wr & hit_sm_evt) ? wbyte[BDM_SM_EVT_W-1:0] : {BDM_SM_EVT_W{1'b0}};

  // Mask registers: OTP load of defined bits beats a bus write
  assign su_mask_nxt = otp.load ? ((su_mask_r & ~BDM_SU_DEFINED) | (otp.step_up_mask & BDM_SU_DEFINED)) :
                       (wr & hit_su_mask) ? wbyte : su_mask_r;
  assign sm_mask_nxt = otp.load ? ((sm_mask_r & ~BDM_SM_DEFINED) | (otp.supply_mask & BDM_SM_DEFINED)) :
                       (wr & hit_sm_mask) ? wbyte : sm_mask_r;

  // Sticky flags, a new event wins over a clear in the same cycle
  assign su_evt_nxt = (su_evt_r & ~su_clr) | su_set;
  assign sm_evt_nxt = (sm_evt_r & ~sm_clr) | sm_set;
  assign su_irqm_nxt = (wr & hit_su_irqm) ? wbyte[BDM_SU_EVT_W-1:0] : su_irqm_r;
  assign sm_irqm_nxt = (wr & hit_sm_irqm) ? wbyte[BDM_SM_EVT_W-1:0] : sm_irqm_r;
  assign irq_nxt = (|(su_evt_nxt & ~su_irqm_nxt)) | (|(sm_evt_nxt & ~sm_irqm_nxt));

  // One wait state, then the answer
  wire logic first_access = access & ~rsp_r.pready;
  assign rsp_nxt = '{
    pready: first_access,
    pslverr: first_access & ~hit_any,
    prdata: (first_access & ~apb_req.pwrite) ? rd_data : {BDM_DW{1'b0}}
  };

  // Mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      su_mask_r <= BDM_STEP_UP_MASK_RST;
      sm_mask_r <= BDM_SUPPLY_MASK_RST;
    end else begin
      su_mask_r <= su_mask_nxt;
      sm_mask_r <= sm_mask_nxt;
    end
  end

  // Event flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      su_evt_r <= '0;
      sm_evt_r <= '0;
    end else begin
      su_evt_r <= su_evt_nxt;
      sm_evt_r <= sm_evt_nxt;
    end
  end

  // Interrupt masks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      su_irqm_r <= '0;
      sm_irqm_r <= '0;
    end else begin
      su_irqm_r <= su_irqm_nxt;
      sm_irqm_r <= sm_irqm_nxt;
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
      rsp_r <= '0;
    end else begin
      irq_r <= irq_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // Live state, never gated by any mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
      prev_r <= '0;
      armed_r <= 1'b0;
    end else begin
      state_r <= live_v;
      prev_r <= live_v;
      armed_r <= 1'b1;
    end
  end

  assign apb_rsp = rsp_r;
  assign irq = irq_r;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_su_loss_masked;
    (loss[BDM_LV_SU] && su_mask_r[BDM_SU_LOSS_BIT] && !su_evt_r[BDM_SU_EVT_GOOD]) |=> !su_evt_r[BDM_SU_EVT_GOOD];
  endproperty
  a_su_loss_masked: assert property (p_su_loss_masked) else $error("masked step-up loss set event");

  property p_su_gain_open;
    (gain[BDM_LV_SU] && !su_mask_r[BDM_SU_GAIN_BIT]) |=> su_evt_r[BDM_SU_EVT_GOOD];
  endproperty
  a_su_gain_open: assert property (p_su_gain_open) else $error("step-up gain event not raised");

  property p_su_oc_open;
    (gain[BDM_LV_OC] && !su_mask_r[BDM_SU_OC_BIT] && !su_irqm_nxt[BDM_SU_EVT_OC]) |=> su_evt_r[BDM_SU_EVT_OC] && irq;
  endproperty
  a_su_oc_open: assert property (p_su_oc_open) else $error("overcurrent event or interrupt missing");

  property p_state_live;
    ##1 state_r[BDM_LV_SU:BDM_LV_OC] == $past(live_v[BDM_LV_SU:BDM_LV_OC]);
  endproperty
  a_state_live: assert property (p_state_live) else $error("state register not following live inputs");

  property p_m2_loss_open;
    (loss[BDM_LV_M2] && !sm_mask_r[BDM_M2_LOSS_BIT]) |=> sm_evt_r[BDM_SM_EVT_M2];
  endproperty
  a_m2_loss_open: assert property (p_m2_loss_open) else $error("monitor two loss event missing");

  property p_m2_gain_masked;
    (gain[BDM_LV_M2] && sm_mask_r[BDM_M2_GAIN_BIT] && !sm_evt_r[BDM_SM_EVT_M2]) |=> !sm_evt_r[BDM_SM_EVT_M2];
  endproperty
  a_m2_gain_masked: assert property (p_m2_gain_masked) else $error("masked monitor two gain set event");

  property p_m1_loss_masked;
    (loss[BDM_LV_M1] && sm_mask_r[BDM_M1_LOSS_BIT] && !sm_evt_r[BDM_SM_EVT_M1]) |=> !sm_evt_r[BDM_SM_EVT_M1];
  endproperty
  a_m1_loss_masked: assert property (p_m1_loss_masked) else $error("masked monitor one loss set event");

  property p_m1_gain_open;
    (gain[BDM_LV_M1] && !sm_mask_r[BDM_M1_GAIN_BIT]) |=> sm_evt_r[BDM_SM_EVT_M1];
  endproperty
  a_m1_gain_open: assert property (p_m1_gain_open) else $error("monitor one gain event missing");

  property p_an_loss_open;
    (loss[BDM_LV_AN] && !sm_mask_r[BDM_AN_LOSS_BIT]) |=> sm_evt_r[BDM_SM_EVT_AN];
  endproperty
  a_an_loss_open: assert property (p_an_loss_open) else $error("analog supply loss event missing");

  property p_an_gain_masked;
    (gain[BDM_LV_AN] && sm_mask_r[BDM_AN_GAIN_BIT] && !sm_evt_r[BDM_SM_EVT_AN]) |=> !sm_evt_r[BDM_SM_EVT_AN];
  endproperty
  a_an_gain_masked: assert property (p_an_gain_masked) else $error("masked analog gain set event");

  property p_otp_load;
    otp.load |=> ((su_mask_r & BDM_SU_DEFINED) == ($past(otp.step_up_mask) & BDM_SU_DEFINED))
             && ((sm_mask_r & BDM_SM_DEFINED) == ($past(otp.supply_mask) & BDM_SM_DEFINED));
  endproperty
  a_otp_load: assert property (p_otp_load) else $error("OTP defaults not loaded");

  property p_su_mask_write;
    (wr && hit_su_mask && !otp.load) |=> su_mask_r == $past(wbyte);
  endproperty
  a_su_mask_write: assert property (p_su_mask_write) else $error("step-up mask write lost");

  property p_sm_mask_write;
    (wr && hit_sm_mask && !otp.load) |=> sm_mask_r == $past(wbyte);
  endproperty
  a_sm_mask_write: assert property (p_sm_mask_write) else $error("supply mask write lost");

  property p_pready_one_wait;
    (access && !rsp_r.pready) |=> rsp_r.pready ##1 !rsp_r.pready;
  endproperty
  a_pready_one_wait: assert property (p_pready_one_wait) else $error("APB answer timing wrong");

  property p_su_loss_open;
    (loss[BDM_LV_SU] && !su_mask_r[BDM_SU_LOSS_BIT]) |=> su_evt_r[BDM_SU_EVT_GOOD];
  endproperty
  a_su_loss_open: assert property (p_su_loss_open) else $error("step-up loss event missing");

  property p_su_gain_masked;
    (gain[BDM_LV_SU] && su_mask_r[BDM_SU_GAIN_BIT] && !su_evt_r[BDM_SU_EVT_GOOD]) |=> !su_evt_r[BDM_SU_EVT_GOOD];
  endproperty
  a_su_gain_masked: assert property (p_su_gain_masked) else $error("masked step-up gain set event");

  property p_su_oc_masked;
    (gain[BDM_LV_OC] && su_mask_r[BDM_SU_OC_BIT] && !su_evt_r[BDM_SU_EVT_OC]) |=> !su_evt_r[BDM_SU_EVT_OC];
  endproperty
  a_su_oc_masked: assert property (p_su_oc_masked) else $error("masked overcurrent set event");

  property p_su_oc_fall_quiet;
    (loss[BDM_LV_OC] && !su_evt_r[BDM_SU_EVT_OC]) |=> !su_evt_r[BDM_SU_EVT_OC];
  endproperty
  a_su_oc_fall_quiet: assert property (p_su_oc_fall_quiet) else $error("overcurrent end set event");

  property p_m2_loss_masked;
    (loss[BDM_LV_M2] && sm_mask_r[BDM_M2_LOSS_BIT] && !sm_evt_r[BDM_SM_EVT_M2]) |=> !sm_evt_r[BDM_SM_EVT_M2];
  endproperty
  a_m2_loss_masked: assert property (p_m2_loss_masked) else $error("masked monitor two loss set event");

  property p_m2_gain_open;
    (gain[BDM_LV_M2] && !sm_mask_r[BDM_M2_GAIN_BIT]) |=> sm_evt_r[BDM_SM_EVT_M2];
  endproperty
  a_m2_gain_open: assert property (p_m2_gain_open) else $error("monitor two gain event missing");

  property p_m1_loss_open;
    (loss[BDM_LV_M1] && !sm_mask_r[BDM_M1_LOSS_BIT]) |=> sm_evt_r[BDM_SM_EVT_M1];
  endproperty
  a_m1_loss_open: assert property (p_m1_loss_open) else $error("monitor one loss event missing");

  property p_m1_gain_masked;
    (gain[BDM_LV_M1] && sm_mask_r[BDM_M1_GAIN_BIT] && !sm_evt_r[BDM_SM_EVT_M1]) |=> !sm_evt_r[BDM_SM_EVT_M1];
  endproperty
  a_m1_gain_masked: assert property (p_m1_gain_masked) else $error("masked monitor one gain set event");

  property p_an_loss_masked;
    (loss[BDM_LV_AN] && sm_mask_r[BDM_AN_LOSS_BIT] && !sm_evt_r[BDM_SM_EVT_AN]) |=> !sm_evt_r[BDM_SM_EVT_AN];
  endproperty
  a_an_loss_masked: assert property (p_an_loss_masked) else $error("masked analog loss set event");

  property p_an_gain_open;
    (gain[BDM_LV_AN] && !sm_mask_r[BDM_AN_GAIN_BIT]) |=> sm_evt_r[BDM_SM_EVT_AN];
  endproperty
  a_an_gain_open: assert property (p_an_gain_open) else $error("analog supply gain event missing");

  property p_monitor_state_live;
    ##1 state_r[BDM_LV_M2:BDM_LV_AN] == $past(live_v[BDM_LV_M2:BDM_LV_AN]);
  endproperty
  a_monitor_state_live: assert property (p_monitor_state_live) else $error("monitor state stale");

  property p_su_mask_hold;
    (!otp.load && !(wr && hit_su_mask)) |=> su_mask_r == $past(su_mask_r);
  endproperty
  a_su_mask_hold: assert property (p_su_mask_hold) else $error("step-up mask changed unasked");

  property p_sm_mask_hold;
    (!otp.load && !(wr && hit_sm_mask)) |=> sm_mask_r == $past(sm_mask_r);
  endproperty
  a_sm_mask_hold: assert property (p_sm_mask_hold) else $error("supply mask changed unasked");

  property p_otp_keeps_reserved;
    otp.load |=> ((su_mask_r & ~BDM_SU_DEFINED) == ($past(su_mask_r) & ~BDM_SU_DEFINED))
             && ((sm_mask_r & ~BDM_SM_DEFINED) == ($past(sm_mask_r) & ~BDM_SM_DEFINED));
  endproperty
  a_otp_keeps_reserved: assert property (p_otp_keeps_reserved) else $error("OTP load hit reserved bits");

  property p_su_set_sticky;
    (|su_set) |=> (su_evt_r & $past(su_set)) == $past(su_set);
  endproperty
  a_su_set_sticky: assert property (p_su_set_sticky) else $error("step-up event lost");

  property p_sm_set_sticky;
    (|sm_set) |=> (sm_evt_r & $past(sm_set)) == $past(sm_set);
  endproperty
  a_sm_set_sticky: assert property (p_sm_set_sticky) else $error("supply event lost");

  property p_su_evt_hold;
    !(wr && hit_su_evt) |=> (su_evt_r & $past(su_evt_r)) == $past(su_evt_r);
  endproperty
  a_su_evt_hold: assert property (p_su_evt_hold) else $error("step-up flag dropped unasked");

  property p_sm_evt_hold;
    !(wr && hit_sm_evt) |=> (sm_evt_r & $past(sm_evt_r)) == $past(sm_evt_r);
  endproperty
  a_sm_evt_hold: assert property (p_sm_evt_hold) else $error("supply flag dropped unasked");

  property p_su_clear;
    (wr && hit_su_evt) |=> (su_evt_r & $past(wbyte[BDM_SU_EVT_W-1:0]) & ~$past(su_set)) == '0;
  endproperty
  a_su_clear: assert property (p_su_clear) else $error("step-up flag not cleared");

  property p_sm_clear;
    (wr && hit_sm_evt) |=> (sm_evt_r & $past(wbyte[BDM_SM_EVT_W-1:0]) & ~$past(sm_set)) == '0;
  endproperty
  a_sm_clear: assert property (p_sm_clear) else $error("supply flag not cleared");

  property p_irq_follows_flags;
    irq == ((|(su_evt_r & ~su_irqm_r)) || (|(sm_evt_r & ~sm_irqm_r)));
  endproperty
  a_irq_follows_flags: assert property (p_irq_follows_flags) else $error("interrupt level wrong");

  property p_pslverr_unmapped;
    (access && !rsp_r.pready && !hit_any) |=> rsp_r.pslverr && (rsp_r.prdata == '0);
  endproperty
  a_pslverr_unmapped: assert property (p_pslverr_unmapped) else $error("unmapped access not refused");

  property p_rsp_idle;
    !rsp_r.pready |-> !rsp_r.pslverr && (rsp_r.prdata == '0);
  endproperty
  a_rsp_idle: assert property (p_rsp_idle) else $error("answer outside the ready cycle");

  c_su_good: cover property (gain[BDM_LV_SU] ##1 su_evt_r[BDM_SU_EVT_GOOD]);
  c_masked_loss: cover property (loss[BDM_LV_M1] && sm_mask_r[BDM_M1_LOSS_BIT]);
  c_irq: cover property (!irq ##1 irq);
  c_set_vs_clear: cover property (|(su_set & su_clr));

endmodule
`default_nettype wire

// *** tb/tb.sv ***
/*
  Self-checking bench for the step-up and supply monitor event mask block.
  Assumes the design package and bdm_mask_ctrl are compiled first.
*/
`default_nettype none
module tb
  import bdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  bdm_apb_req_type req = '{pstrb: 4'hF, default: '0};
  bdm_apb_rsp_type rsp;
  bdm_live_type live = '0;
  bdm_otp_type otp = '0;
  logic irq;
  logic [4:0] lv = 5'h00;
  logic [31:0] q;
  logic e;
  int err_count = 0;
  int samples_checked = 0;
  // One row per detection: mask place, live bit, edge, event place
  logic [11:0] ma [9] = '{12'h0B0, 12'h0B0, 12'h0B0, 12'h0B4, 12'h0B4, 12'h0B4, 12'h0B4, 12'h0B4, 12'h0B4};
  int mb [9] = '{0, 2, 3, 0, 1, 2, 3, 4, 5};
  int lb [9] = '{0, 1, 1, 2, 2, 3, 3, 4, 4};
  logic rs [9] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [11:0] ea [9] = '{12'h100, 12'h100, 12'h100, 12'h104, 12'h104, 12'h104, 12'h104, 12'h104, 12'h104};
  int eb [9] = '{0, 1, 1, 0, 0, 1, 1, 2, 2};

  bdm_mask_ctrl dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(req),
    .apb_rsp(rsp),
    .live(live),
    .otp(otp),
    .irq(irq)
  );

  always #2.5 pclk = ~pclk;

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, ex, got);
    end
  endtask

  // APB transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h1, 32'h0);
    rq = rsp.prdata;
    re = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] ex);
    xfer(1'b0, a, 32'h0, q, e);
    chk($sformatf("read %h", a), ex, q);
    chk($sformatf("pslverr %h", a), 32'h0, {31'h0, e});
  endtask

  task automatic drive_live();
    @(posedge pclk);
    live <= lv;
    repeat (2) @(posedge pclk);
  endtask

  task automatic irqc(input logic ex);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, ex}, {31'h0, irq});
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h0B0, 32'h0);
    rdc(12'h0B4, 32'h0);
    wr(12'h0B0, 32'hFF);
    wr(12'h0B4, 32'hFF);
    rdc(12'h0B0, 32'hFF);
    rdc(12'h0B4, 32'hFF);
    for (int i = 0; i < 9; i++) begin
      wr(12'h0B0, 32'hFF);
      wr(12'h0B4, 32'hFF);
      lv[lb[i]] = ~rs[i];
      drive_live();
      wr(12'h100, 32'hFF);
      wr(12'h104, 32'hFF);
      // Only this detection masked in its register, other register all masked
      wr(ma[i], 32'h1 << mb[i]);
      lv[lb[i]] = rs[i];
      drive_live();
      rdc(ea[i], 32'h0);
      rdc(12'h108, {27'h0, lv});
      wr(ma[i], 32'hFF);
      lv[lb[i]] = ~rs[i];
      drive_live();
      wr(ea[i], 32'hFF);
      // Only this detection open, reserved bits set
      wr(ma[i], 32'hFF ^ (32'h1 << mb[i]));
      lv[lb[i]] = rs[i];
      drive_live();
      rdc(ea[i], 32'h1 << eb[i]);
      irqc(1'b1);
      wr(ma[i], 32'hFF);
      wr(ea[i], 32'h1 << eb[i]);
      rdc(ea[i], 32'h0);
      irqc(1'b0);
      lv = 5'h00;
      drive_live();
    end
    wr(12'h104, 32'hFF);
    wr(12'h100, 32'hFF);
    wr(12'h0B0, 32'h00);
    lv[0] = 1'b1;
    drive_live();
    irqc(1'b1);
    wr(12'h10C, 32'h1);
    irqc(1'b0);
    wr(12'h10C, 32'h0);
    irqc(1'b1);
    wr(12'h100, 32'h1);
    irqc(1'b0);
    // Supply flag against its interrupt mask
    wr(12'h0B4, 32'h00);
    lv[2] = 1'b1;
    drive_live();
    irqc(1'b1);
    wr(12'h110, 32'h1);
    irqc(1'b0);
    rdc(12'h104, 32'h1);
    wr(12'h104, 32'h1);
    wr(12'h110, 32'h0);
    irqc(1'b0);
    // Power-up defaults over stored all-ones
    wr(12'h0B0, 32'hFF);
    wr(12'h0B4, 32'hFF);
    @(posedge pclk);
    otp <= '{load: 1'b1, step_up_mask: 8'h26, supply_mask: 8'h15};
    @(posedge pclk);
    otp.load <= 1'b0;
    rdc(12'h0B0, {24'h0, (8'hFF & ~BDM_SU_DEFINED) | (8'h26 & BDM_SU_DEFINED)});
    rdc(12'h0B4, {24'h0, (8'hFF & ~BDM_SM_DEFINED) | (8'h15 & BDM_SM_DEFINED)});
    // Write without its byte strobe, then a misaligned write
    req.pstrb <= 4'h0;
    wr(12'h0B0, 32'h00);
    req.pstrb <= 4'hF;
    rdc(12'h0B0, 32'hF6);
    xfer(1'b1, 12'h0B1, 32'h0, q, e);
    chk("misaligned pslverr", 32'h1, {31'h0, e});
    rdc(12'h0B0, 32'hF6);
    xfer(1'b0, 12'h0C0, 32'h0, q, e);
    chk("unmapped pslverr", 32'h1, {31'h0, e});
    chk("unmapped prdata", 32'h0, q);
    end_of_test();
  end
endmodule
`default_nettype wire
